// [shared/msir_pkg.sv]
package msir_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_RX_STATUS  = 8'h00; // w1c receive flags
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h04; // clear on read
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h08; // write-only
  localparam logic [7:0] OFF_IRQ_DISABL = 8'h0c; // write-only
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h10; // read-only
  localparam logic [7:0] OFF_PAUSE_TIME = 8'h14; // read-only count

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int unsigned RX_W  = 3;  // receive flags width
  localparam int unsigned IRQ_W = 14; // interrupt vector width
  localparam int unsigned RX_NO_BUF  = 0;
  localparam int unsigned RX_STORED  = 1;
  localparam int unsigned RX_OVERRUN = 2;
  localparam int unsigned IRQ_MGMT      = 0;
  localparam int unsigned IRQ_RX_DONE   = 1;
  localparam int unsigned IRQ_RX_OWNED  = 2;
  localparam int unsigned IRQ_TX_OWNED  = 3;
  localparam int unsigned IRQ_TX_UNDER  = 4;
  localparam int unsigned IRQ_RETRY     = 5;
  localparam int unsigned IRQ_TX_EXHST  = 6;
  localparam int unsigned IRQ_TX_DONE   = 7;
  localparam int unsigned IRQ_RX_OVR    = 10;
  localparam int unsigned IRQ_BUS_ERR   = 11;
  localparam int unsigned IRQ_PAUSE_RX  = 12;
  localparam int unsigned IRQ_PAUSE_0   = 13;

  // ---------------------------------------------------------------
  // reset values and implemented bits
  // ---------------------------------------------------------------
  localparam logic [IRQ_W-1:0] IRQ_VALID  = 14'h3cff; // bits 8,9 none
  localparam logic [IRQ_W-1:0] IRQ_RST    = 14'h0000;
  localparam logic [IRQ_W-1:0] MASK_RST   = 14'h3cff; // all masked
  localparam logic [RX_W-1:0]  RX_RST     = 3'h0;
  localparam logic [31:0]      RDATA_RST  = 32'h0000_0000;

  // ---------------------------------------------------------------
  // pause timing
  // ---------------------------------------------------------------
  localparam int unsigned PTIME_W   = 16;  // pause count width
  localparam int unsigned SLOT_BITS = 512; // bit times per decrement

  // ---------------------------------------------------------------
  // bus encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  // one-cycle event pulses from the mac datapath and dma engines
  typedef struct packed {
    logic mgmt_op_done;        // phy management op finished
    logic rx_frame_done;       // frame written to memory
    logic rx_descr_owned_hit;  // rx fetch found used descriptor
    logic rx_fetch_ok;         // rx fetch found usable descriptor
    logic rx_overrun_event;    // rx store failed (grant/bus error)
    logic tx_descr_owned_hit;  // tx descriptor read with used bit
    logic tx_late_data;        // tx data not fetched in time
    logic tx_bus_error;        // tx dma saw error response
    logic rx_bus_error;        // rx dma saw error response
    logic tx_midframe_used;    // used descriptor in mid frame
    logic tx_qptr_written;     // new tx queue pointer written
    logic retry_limit_event;   // retry limit exceeded
    logic tx_midframe_exhaust; // buffers ran out mid frame
    logic tx_frame_done;       // frame fully transmitted
    logic pause_frame_seen;    // valid pause frame received
  } msir_evt_s;

  // pause timer load and bit clock
  typedef struct packed {
    logic               load;     // pulse: load new pause time
    logic [PTIME_W-1:0] value;    // time carried by pause frame
    logic               bit_tick; // one pulse per bit time
  } msir_pause_s;

  // control back to the receive dma
  typedef struct packed {
    logic rx_retry_pending; // reread descriptor at frame start
    logic rx_buf_recover;   // pulse: reclaim the overrun buffer
  } msir_dma_s;

endpackage

// [src/msir_pause_cnt.sv]
`timescale 1ns/1ps
// pause time counter: counts down once per slot of bit times
module msir_pause_cnt #(
  parameter int unsigned PTIME_W   = msir_pkg::PTIME_W,
  parameter int unsigned SLOT_BITS = msir_pkg::SLOT_BITS
) (
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // load and bit clock
  input  wire logic               load,
  input  wire logic [PTIME_W-1:0] load_value,
  input  wire logic               bit_tick,
  // state and event
  output logic      [PTIME_W-1:0] count,
  output logic                    zero_pulse
);

  localparam int unsigned PRE_W = $clog2(SLOT_BITS);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(SLOT_BITS - 1);

  initial begin
    if (SLOT_BITS < 2 || PTIME_W < 1) begin
      $error("msir_pause_cnt: bad parameters");
    end
  end

  typedef struct packed {
    logic [PTIME_W-1:0] cnt;  // remaining pause slots
    logic [PRE_W-1:0]   pre;  // bit times within the slot
    logic               zero; // registered arrival at zero
  } msir_pc_s;

  msir_pc_s st_ff;
  msir_pc_s nxt_st;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.zero = 1'b0;
    if (load) begin
      // a new frame restarts the slot so the first step is whole
      nxt_st.cnt = load_value;
      nxt_st.pre = '0;
    end else if (bit_tick && st_ff.cnt != '0) begin
      if (st_ff.pre == PRE_LAST) begin
        nxt_st.pre  = '0;
        nxt_st.cnt  = st_ff.cnt - PTIME_W'(1);
        nxt_st.zero = (st_ff.cnt == PTIME_W'(1));
      end else begin
        nxt_st.pre = st_ff.pre + PRE_W'(1);
      end
    end
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign count      = st_ff.cnt;
  assign zero_pulse = st_ff.zero;

endmodule // msir_pause_cnt

// [src/msir_regs.sv]
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - rx flags clear by writing one only
// - no-buffer flag set on every failed fetch
// - after failed fetch, reread pointer each frame
// - frame-stored flag set on stored frame
// - overrun flag set; affected buffer reclaimed
// - management done sets bit 0, read clears
// - receive complete sets bit 1, read clears
// - rx used descriptor read sets bit 2
// - tx used descriptor read sets bit 3
// - tx late data or bus error: bit 4
// - mid-frame used or new pointer: bit 4
// - retry limit event at bit 5 everywhere
// - mid-frame buffer exhaustion sets bit 6
// - transmit complete sets bit 7
// - receive overrun flag setting sets bit 10
// - any dma bus error sets bit 11
// - valid pause frame sets bit 12
// - pause counter reaching zero sets bit 13
// - enable write of one unmasks source
// - disable write of one masks source
// - mask register reads per-source mask state
// - pause counter steps every 512 bit times
module msir_regs #(
  parameter int unsigned ADDR_W    = 8,
  parameter int unsigned SLOT_BITS = msir_pkg::SLOT_BITS
) (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // mac events and pause timing
  input  wire msir_pkg::msir_evt_s   evt,
  input  wire msir_pkg::msir_pause_s pause,
  // dma control and interrupt
  output msir_pkg::msir_dma_s        dma_ctl,
  output logic                       irq
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  initial begin
    if (ADDR_W < 5 || ADDR_W > 32) begin
      $error("msir_regs: ADDR_W must cover the map");
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [msir_pkg::RX_W-1:0]  rx;      // receive flags
    logic [msir_pkg::IRQ_W-1:0] isr;     // interrupt status
    logic [msir_pkg::IRQ_W-1:0] mask;    // 1 = source masked
    logic                       wr_pend; // write data phase due
    logic [ADDR_W-1:0]          wr_addr; // address of that write
    logic [31:0]                rdata;   // read data for hrdata
    logic                       retry;   // rx descriptor retry
    logic                       recover; // buffer reclaim pulse
    logic                       irq;     // registered request
  } msir_st_s;

  msir_st_s st_ff;
  msir_st_s nxt_st;

  logic [msir_pkg::PTIME_W-1:0] pause_count; // current pause time
  logic                         pause_zero;  // counter hit zero

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // true when an address names the given register offset
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        off);
    hit = (a == ADDR_W'(off));
  endfunction

  // collect this cycle's interrupt sources into one vector
  function automatic logic [msir_pkg::IRQ_W-1:0] irq_sets(
    input msir_pkg::msir_evt_s e,
    input logic                pz);
    logic [msir_pkg::IRQ_W-1:0] v;
    v = '0;
    v[msir_pkg::IRQ_MGMT]     = e.mgmt_op_done;
    v[msir_pkg::IRQ_RX_DONE]  = e.rx_frame_done;
    v[msir_pkg::IRQ_RX_OWNED] = e.rx_descr_owned_hit;
    v[msir_pkg::IRQ_TX_OWNED] = e.tx_descr_owned_hit;
    v[msir_pkg::IRQ_TX_UNDER] = e.tx_late_data
                              | e.tx_bus_error
                              | e.tx_midframe_used
                              | e.tx_qptr_written;
    v[msir_pkg::IRQ_RETRY]    = e.retry_limit_event;
    v[msir_pkg::IRQ_TX_EXHST] = e.tx_midframe_exhaust;
    v[msir_pkg::IRQ_TX_DONE]  = e.tx_frame_done;
    v[msir_pkg::IRQ_RX_OVR]   = e.rx_overrun_event;
    v[msir_pkg::IRQ_BUS_ERR]  = e.tx_bus_error
                              | e.rx_bus_error;
    v[msir_pkg::IRQ_PAUSE_RX] = e.pause_frame_seen;
    v[msir_pkg::IRQ_PAUSE_0]  = pz;
    irq_sets = v;
  endfunction

  // ---------------------------------------------------------------
  // pause time counter
  // ---------------------------------------------------------------
  msir_pause_cnt #(
    .PTIME_W   (msir_pkg::PTIME_W),
    .SLOT_BITS (SLOT_BITS)
  ) u_pause (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .load       (pause.load),
    .load_value (pause.value),
    .bit_tick   (pause.bit_tick),
    .count      (pause_count),
    .zero_pulse (pause_zero)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic              acc;   // address phase accepted this edge
  logic [ADDR_W-1:0] a_now; // word-aligned address of that phase

  // hsize is not decoded: every transfer is served as a whole word
  assign acc   = hsel && hready && (htrans == msir_pkg::HTRANS_NONSEQ);
  assign a_now = {haddr[ADDR_W-1:2], 2'b00};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [msir_pkg::IRQ_W-1:0] set_v; // this cycle's irq sources
    logic [31:0]                rd;    // value read this cycle
    set_v = irq_sets(evt, pause_zero);
    rd    = '0;
    nxt_st = st_ff;
    nxt_st.recover = 1'b0;

    // write data phase: applied first so that events below win
    if (st_ff.wr_pend) begin
      if (hit(st_ff.wr_addr, msir_pkg::OFF_RX_STATUS)) begin
        // ones clear, zeros keep; a write never sets
        nxt_st.rx = st_ff.rx & ~hwdata[msir_pkg::RX_W-1:0];
      end else if (hit(st_ff.wr_addr, msir_pkg::OFF_IRQ_ENABLE)) begin
        // only the ones written unmask
        nxt_st.mask = st_ff.mask
                    & ~(hwdata[msir_pkg::IRQ_W-1:0]
                        & msir_pkg::IRQ_VALID);
      end else if (hit(st_ff.wr_addr, msir_pkg::OFF_IRQ_DISABL)) begin
        // only the ones written mask
        nxt_st.mask = st_ff.mask
                    | (hwdata[msir_pkg::IRQ_W-1:0]
                       & msir_pkg::IRQ_VALID);
      end
      // other offsets: writes have no effect, answer stays okay
    end

    // hardware sets, after any clear so an event is never lost
    if (evt.rx_descr_owned_hit) begin
      nxt_st.rx[msir_pkg::RX_NO_BUF] = 1'b1;
    end
    if (evt.rx_frame_done) begin
      nxt_st.rx[msir_pkg::RX_STORED] = 1'b1;
    end
    if (evt.rx_overrun_event) begin
      nxt_st.rx[msir_pkg::RX_OVERRUN] = 1'b1;
      nxt_st.recover = 1'b1;
    end
    nxt_st.isr = st_ff.isr | (set_v & msir_pkg::IRQ_VALID);

    // descriptor retry: held from a failed fetch until one succeeds
    if (evt.rx_descr_owned_hit) begin
      nxt_st.retry = 1'b1;
    end else if (evt.rx_fetch_ok) begin
      nxt_st.retry = 1'b0;
    end

    // address phase: note writes, answer reads from updated state
    nxt_st.wr_pend = acc && hwrite;
    if (acc) begin
      nxt_st.wr_addr = a_now;
    end
    if (acc && !hwrite) begin
      if (hit(a_now, msir_pkg::OFF_RX_STATUS)) begin
        rd = 32'(nxt_st.rx);
      end else if (hit(a_now, msir_pkg::OFF_IRQ_STATUS)) begin
        rd = 32'(nxt_st.isr);
        // reported bits clear; sets of this cycle are in rd
        nxt_st.isr = nxt_st.isr & ~nxt_st.isr;
      end else if (hit(a_now, msir_pkg::OFF_IRQ_MASK)) begin
        rd = 32'(nxt_st.mask);
      end else if (hit(a_now, msir_pkg::OFF_PAUSE_TIME)) begin
        rd = 32'(pause_count);
      end
      // write-only and unmapped offsets read as zero
      nxt_st.rdata = rd;
    end

    // request follows status and mask after this cycle's updates
    nxt_st.irq = |(nxt_st.isr & ~nxt_st.mask);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff.rx      <= msir_pkg::RX_RST;
      st_ff.isr     <= msir_pkg::IRQ_RST;
      st_ff.mask    <= msir_pkg::MASK_RST;
      st_ff.wr_pend <= 1'b0;
      st_ff.wr_addr <= '0;
      st_ff.rdata   <= msir_pkg::RDATA_RST;
      st_ff.retry   <= 1'b0;
      st_ff.recover <= 1'b0;
      st_ff.irq     <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // zero wait states: every phase completes in one cycle
  assign hreadyout = 1'b1;
  assign hresp     = msir_pkg::HRESP_OKAY;
  assign hrdata    = st_ff.rdata;
  assign irq       = st_ff.irq;

  // dma reads this as "reread pointer at next frame start"
  assign dma_ctl.rx_retry_pending = st_ff.retry;
  assign dma_ctl.rx_buf_recover   = st_ff.recover;

endmodule // msir_regs

// [test/msir_regs_asserts.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port-level checker for the status and interrupt registers
// ---------------------------------------------------------------
module msir_regs_asserts (
  // clock and reset
  input wire logic                  hclk,
  input wire logic                  hresetn,
  // bus side
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic [31:0]           hrdata,
  // mac side
  input wire msir_pkg::msir_evt_s   evt,
  input wire msir_pkg::msir_pause_s pause,
  input wire msir_pkg::msir_dma_s   dma_ctl,
  input wire logic                  irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       take;     // transfer accepted this edge
  logic [2:0] quiet_ff; // cycles since last bit tick, saturates
  assign take = hsel && hready && htrans == msir_pkg::HTRANS_NONSEQ;
  // a pause countdown in flight could set bit 13 between two reads
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) quiet_ff <= 3'h0;
    else if (pause.bit_tick) quiet_ff <= 3'h0;
    else if (quiet_ff != 3'h7) quiet_ff <= quiet_ff + 3'h1;
  end
  sequence s_rd(a);
    take && !hwrite && haddr[7:0] == a;
  endsequence
  sequence s_wr(a, d);
    take && hwrite && haddr[7:0] == a ##1 hwdata[13:0] == d;
  endsequence
  // status read in a cycle where no source can fire
  sequence s_isr_q;
    take && !hwrite && haddr[7:0] == msir_pkg::OFF_IRQ_STATUS &&
      evt == '0 && quiet_ff == 3'h7;
  endsequence
  // all-ones write to the enable or the disable register
  sequence s_en_all;
    s_wr(msir_pkg::OFF_IRQ_ENABLE, 14'h3fff);
  endsequence
  sequence s_dis_all;
    s_wr(msir_pkg::OFF_IRQ_DISABL, 14'h3fff);
  endsequence
  AST_ISR_CLR: assert property (
    s_isr_q ##1 (evt == '0 && !take) ##1 s_isr_q |=> hrdata == 32'h0)
    else $error("status not cleared by read");
  AST_MASK_EN: assert property (
    s_en_all ##1 s_rd(msir_pkg::OFF_IRQ_MASK) |=> hrdata[13:0] == 14'h0)
    else $error("enable left a source masked");
  AST_MASK_DIS: assert property (
    s_dis_all ##1 s_rd(msir_pkg::OFF_IRQ_MASK)
    |=> hrdata[13:0] == msir_pkg::MASK_RST)
    else $error("disable left a source open");
  AST_IRQ_OFF: assert property (s_dis_all |=> !irq)
    else $error("irq high with all sources masked");
  AST_IRQ_ON: assert property (
    s_en_all ##1 (evt.mgmt_op_done && !take) |=> irq)
    else $error("irq missing");
  AST_RETRY_SET: assert property (evt.rx_descr_owned_hit
    |=> dma_ctl.rx_retry_pending) else $error("retry not pending");
  AST_RETRY_CLR: assert property (evt.rx_fetch_ok &&
    !evt.rx_descr_owned_hit |=> !dma_ctl.rx_retry_pending)
    else $error("retry stuck");
  AST_RECOVER: assert property (evt.rx_overrun_event
    |=> dma_ctl.rx_buf_recover) else $error("buffer not recovered");
  AST_RECOVER_ONLY: assert property (dma_ctl.rx_buf_recover
    |-> $past(evt.rx_overrun_event)) else $error("spurious recover");
  AST_RDATA_HOLD: assert property (!(take && !hwrite)
    |=> $stable(hrdata)) else $error("read data moved");
endmodule // msir_regs_asserts

bind msir_regs msir_regs_asserts u_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .evt, .pause, .dma_ctl, .irq);

// [test/tb_msir_regs.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// self-checking bench for the status and interrupt registers
// ---------------------------------------------------------------
module tb_msir_regs;
  logic                  hclk, hresetn, hsel, hwrite, hready;
  logic                  hreadyout, hresp, irq;
  logic [31:0]           haddr, hwdata, hrdata, rd, w;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [13:0]           mask_exp; // mirror of the mask state
  logic [16:0]           ex;       // expected {rx, isr}
  msir_pkg::msir_evt_s   evt;
  msir_pkg::msir_pause_s pause;
  msir_pkg::msir_dma_s   dma_ctl;
  int                    err_total = 0, total_checks = 0, cyc = 0;
  assign hready = hreadyout; // single slave
  // short slot keeps the countdown test brief
  msir_regs #(.ADDR_W(8), .SLOT_BITS(4)) dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .evt(evt),
    .pause(pause), .dma_ctl(dma_ctl), .irq(irq));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end
  task check(input logic [31:0] seen, exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  // one single transfer: address phase, then data phase
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hwrite <= wr;
    haddr <= {24'h0, a};
    htrans <= msir_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string s);
    bus(1'b0, a, $urandom);
    check(rd, exp, s);
  endtask
  task pulse(input logic [14:0] v);
    evt <= msir_pkg::msir_evt_s'(v);
    @(posedge hclk);
    evt <= '0;
  endtask
  // {rx flags, status bits} raised by the event at packed bit i
  function automatic logic [16:0] exp_evt(input int i);
    case (i)
      14: return 17'h00001;
      13: return 17'h08002;
      12: return 17'h04004;
      10: return 17'h10400;
      9: return 17'h00008;
      8, 5, 4: return 17'h00010;
      7: return 17'h00810;
      6: return 17'h00800;
      3: return 17'h00020;
      2: return 17'h00040;
      1: return 17'h00080;
      0: return 17'h01000;
      default: return 17'h0;
    endcase
  endfunction
  task report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    w = $urandom(32'ha5f41990);
    {hresetn, hwrite, haddr, hwdata, htrans} = '0;
    {hsel, hsize, evt, pause} = {1'b1, 3'h2, 15'h0, 18'h0};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, write-only and unmapped reads
    rdchk(msir_pkg::OFF_IRQ_MASK, 32'h3cff, "mask rst");
    rdchk(msir_pkg::OFF_IRQ_STATUS, 32'h0, "isr rst");
    rdchk(msir_pkg::OFF_RX_STATUS, 32'h0, "rx rst");
    rdchk(msir_pkg::OFF_IRQ_ENABLE, 32'h0, "enable wo");
    rdchk(8'h3c, 32'h0, "unmapped");
    check(irq, 32'h0, "irq rst");
    bus(1'b1, msir_pkg::OFF_IRQ_ENABLE, 32'h3fff);
    rdchk(msir_pkg::OFF_IRQ_MASK, 32'h0, "mask open");
    $display("test reset done");
    // every event source alone; descending so retry clears after set
    for (int i = 14; i >= 0; i--) begin
      bus(1'b1, msir_pkg::OFF_IRQ_ENABLE, 32'h3fff);
      ex = exp_evt(i);
      pulse(15'h1 << i);
      rdchk(msir_pkg::OFF_RX_STATUS, {29'h0, ex[16:14]}, "rx set");
      check(irq, {31'h0, |ex[13:0]}, "irq evt");
      rdchk(msir_pkg::OFF_IRQ_STATUS, {18'h0, ex[13:0]}, "isr");
      rdchk(msir_pkg::OFF_IRQ_STATUS, 32'h0, "isr rc");
      check(irq, 32'h0, "irq rc");
      bus(1'b1, msir_pkg::OFF_RX_STATUS, 32'hffff_fff8);
      rdchk(msir_pkg::OFF_RX_STATUS, {29'h0, ex[16:14]}, "rx kept");
      bus(1'b1, msir_pkg::OFF_RX_STATUS, 32'hffff_ffff);
      rdchk(msir_pkg::OFF_RX_STATUS, 32'h0, "rx w1c");
    end
    // frame stored lands on the edge that applies a write-one clear
    fork
      bus(1'b1, msir_pkg::OFF_RX_STATUS, 32'hffff_ffff);
      begin
        @(posedge hclk);
        pulse(15'h2000);
      end
    join
    rdchk(msir_pkg::OFF_RX_STATUS, 32'h2, "set wins");
    $display("test events done");
    // random masks, then all events at once
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, msir_pkg::OFF_IRQ_DISABL, 32'h3fff);
      rdchk(msir_pkg::OFF_IRQ_MASK, 32'h3cff, "mask all");
      w = $urandom;
      bus(1'b1, msir_pkg::OFF_IRQ_ENABLE, w);
      mask_exp = msir_pkg::MASK_RST & ~w[13:0];
      rdchk(msir_pkg::OFF_IRQ_MASK, {18'h0, mask_exp}, "en");
      w = $urandom;
      bus(1'b1, msir_pkg::OFF_IRQ_DISABL, w);
      mask_exp = (mask_exp | w[13:0]) & msir_pkg::IRQ_VALID;
      rdchk(msir_pkg::OFF_IRQ_MASK, {18'h0, mask_exp}, "dis");
      pulse(15'h7fff);
      bus(1'b1, msir_pkg::OFF_RX_STATUS, 32'h0);
      check(irq, {31'h0, |(14'h1cff & ~mask_exp)}, "irq mask");
      check(dma_ctl.rx_retry_pending, 32'h1, "retry wins");
      rdchk(msir_pkg::OFF_IRQ_STATUS, 32'h1cff, "isr all");
    end
    $display("test masks done");
    // pause countdown from 2, one slot at a time
    pause <= '{load: 1'b1, value: 16'h2, bit_tick: 1'b0};
    @(posedge hclk);
    pause <= '{load: 1'b0, value: 16'h2, bit_tick: 1'b1};
    repeat (4) @(posedge hclk);
    pause.bit_tick <= 1'b0;
    rdchk(msir_pkg::OFF_PAUSE_TIME, 32'h1, "pause step");
    rdchk(msir_pkg::OFF_IRQ_STATUS, 32'h0, "no zero yet");
    pause.bit_tick <= 1'b1;
    repeat (4) @(posedge hclk);
    pause.bit_tick <= 1'b0;
    repeat (3) @(posedge hclk);
    rdchk(msir_pkg::OFF_IRQ_STATUS, 32'h2000, "pause zero");
    $display("test pause done");
    report_and_stop();
  end
endmodule // tb_msir_regs
